// ==== logic/scr_map.svh ====
// Register offsets, field positions and reset values of the scaler readout
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH

// ****************************************
// Address map
// ****************************************
`define SCR_ADDR_W       24
`define SCR_WIN_BASE     24'h80_0000
`define SCR_WIN_LAST     24'hFF_FFFC
`define SCR_WIN_BIT      23
`define SCR_OFS_CTRL     24'h00_0100
`define SCR_OFS_PAGE     24'h00_0104
`define SCR_OFS_STAT     24'h00_0108

// ****************************************
// Fields and reset values
// ****************************************
`define SCR_CTRL_FMT_LSB 0
`define SCR_CTRL_FMT_MSB 1
`define SCR_CTRL_MODE    2
`define SCR_CTRL_RST     32'h0000_0004
`define SCR_PAGE_RST     32'h0000_0000
`define SCR_PAGE_MB      64
`define SCR_STAT_EMPTY   31
`define SCR_STAT_FULL    30

`endif

// ==== logic/scr_pkg.sv ====
// Types shared by the scaler readout packer
package scr_pkg;

  typedef enum logic [1:0] {
    SCR_FMT32 = 2'b00,
    SCR_FMT24 = 2'b01,
    SCR_FMT16 = 2'b10,
    SCR_FMT8  = 2'b11
  } scr_fmt_e;

  typedef struct packed {
    logic [31:0] count;
    logic [4:0]  channel;
  } scr_sample_s;

  typedef struct packed {
    logic     fifo_mode;
    scr_fmt_e fmt;
  } scr_ctrl_s;

endpackage : scr_pkg

// ==== logic/scr_fifo.sv ====
// Word store with first-in first-out order for the readout window
`timescale 1ns/1ps
module scr_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 64,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          clk_sys,
  input  wire logic          arst_n,
  input  wire logic          push,
  input  wire logic [W-1:0]  push_data,
  input  wire logic          pop,
  output logic      [W-1:0]  head,
  output logic               empty,
  output logic               full,
  output logic      [AW:0]   level
);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   level_r;
  wire           do_push = push && !full;
  wire           do_pop  = pop && !empty;

  assign head  = mem[rd_ptr_r];
  assign empty = (level_r == '0);
  assign full  = (level_r == (AW+1)'(DEPTH));
  assign level = level_r;

  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem[wr_ptr_r] <= push_data;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r  <= '0;
    end else begin
      wr_ptr_r <= do_push ? AW'((wr_ptr_r + 1'b1) % DEPTH) : wr_ptr_r;
      rd_ptr_r <= do_pop ? AW'((rd_ptr_r + 1'b1) % DEPTH) : rd_ptr_r;
      level_r  <= level_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

endmodule : scr_fifo

// ==== logic/scr_readout.sv ====
// Scaler word packer with FIFO emulation readout window
// Function
// R1: Window 0x800000-0xFFFFFC returns next stored word
// R2: Single and block reads served alike
// R3: Empty FIFO read raises bus error
// R4: Data readable only in FIFO mode
// R5: Non-incrementing blocks of any length served
// R6: Incrementing master splits blocks inside window
// R7: Page register selects 64 MByte memory page
// R8: Two-bit field selects word packing
// R9: 32-bit format carries raw count
// R10: 24-bit format adds user bits, channel
// R11: User bits latched at sample time
// R12: 16-bit format pairs channels N, N+1
// R13: 8-bit format packs four channels
// R14: Strict FIFO order, each word once
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "scr_map.svh"
module scr_readout import scr_pkg::*; #(
  parameter int DEPTH  = 64,
  parameter int MEM_MB = 64,
  parameter int PAGE_W = 3
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic [23:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  output logic             bus_berr,
  input  wire scr_sample_s smp,
  input  wire logic        smp_valid,
  output logic             smp_ready,
  input  wire logic [1:0]  user_pin,
  output logic [PAGE_W-1:0] mem_page
);

  localparam int AW = $clog2(DEPTH);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [1:0] last_lane(input scr_fmt_e f);
    case (f)
      SCR_FMT16: last_lane = 2'd1;
      SCR_FMT8:  last_lane = 2'd3;
      default:   last_lane = 2'd0;
    endcase
  endfunction : last_lane

  function automatic logic [31:0] lane_ins(input scr_fmt_e f,
                                           input logic [31:0] acc,
                                           input logic [31:0] c,
                                           input logic [1:0] lane);
    logic [31:0] r;
    r = acc;
    if (f == SCR_FMT16) begin
      if (lane[0]) begin
        r[31:16] = c[15:0];
      end else begin
        r[15:0] = c[15:0];
      end
    end else begin
      case (lane)
        2'd0:    r[7:0]   = c[7:0];
        2'd1:    r[15:8]  = c[7:0];
        2'd2:    r[23:16] = c[7:0];
        default: r[31:24] = c[7:0];
      endcase
    end
    lane_ins = r;
  endfunction : lane_ins

  function automatic logic in_win(input logic [23:0] a);
    in_win = a[`SCR_WIN_BIT];
  endfunction : in_win

  // ****************************************
  // Registers and state
  // ****************************************
  scr_ctrl_s         ctrl_r;
  logic [PAGE_W-1:0] page_r;
  logic [31:0]       rdata_r;
  logic              berr_r;
  logic              ready_r;
  logic [31:0]       acc_r;
  logic [1:0]        lane_r;
  logic [1:0]        usr_s1_r;
  logic [1:0]        usr_s2_r;
  logic [1:0]        usr_s3_r;
  logic [1:0]        usr_r;

  // ****************************************
  // Decode
  // ****************************************
  wire win_rd   = bus_rd && in_win(bus_addr);
  wire ctrl_hit = (bus_addr == `SCR_OFS_CTRL);
  wire page_hit = (bus_addr == `SCR_OFS_PAGE);
  wire stat_hit = (bus_addr == `SCR_OFS_STAT);
  wire ctrl_wr  = bus_wr && ctrl_hit;
  wire page_wr  = bus_wr && page_hit;

  // ****************************************
  // FIFO and packing
  // ****************************************
  logic [31:0] head;
  logic        empty;
  logic        full;
  logic [AW:0] level;

  wire         fmode    = ctrl_r.fifo_mode;
  // Address offset inside window never steers which word is returned
  wire         pop      = win_rd && fmode && !empty; // [R1] [R2] [R5] [R14]
  wire         take     = smp_valid && ready_r && !full;
  wire         last     = (lane_r == last_lane(ctrl_r.fmt)); // [R8]
  wire [31:0]  acc_ins  = lane_ins(ctrl_r.fmt, acc_r, smp.count, lane_r);
  wire [31:0]  tag_word = {usr_r[1], usr_r[0], 1'b0, smp.channel,
                           smp.count[23:0]}; // [R10] [R11]
  wire         push     = take && last;
  logic [31:0] push_data;

  always_comb begin
    case (ctrl_r.fmt) // [R8]
      SCR_FMT32: push_data = smp.count; // [R9]
      SCR_FMT24: push_data = tag_word; // [R10]
      SCR_FMT16: push_data = acc_ins; // [R12]
      SCR_FMT8:  push_data = acc_ins; // [R13]
      default:   push_data = smp.count;
    endcase
  end

  scr_fifo #(
    .W     (32),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .push      (push),
    .push_data (push_data),
    .pop       (pop),
    .head      (head),
    .empty     (empty),
    .full      (full),
    .level     (level)
  );

  // Room check leaves one slot for the accept already in flight
  wire [AW:0] level_nxt = level + (AW+1)'(push) - (AW+1)'(pop);
  wire        ready_nxt = (level_nxt < (AW+1)'(DEPTH - 1));

  wire [1:0]  lane_nxt = ctrl_wr ? 2'd0 :
                         push    ? 2'd0 :
                         take    ? lane_r + 2'd1 : lane_r;
  wire [31:0] acc_nxt  = (ctrl_wr || push) ? 32'h0000_0000 :
                         take ? acc_ins : acc_r;

  // ****************************************
  // Page select
  // ****************************************
  // Paging applies only when more than one page of memory is fitted
  wire [PAGE_W-1:0] page_nxt = (MEM_MB > `SCR_PAGE_MB) ?
                               bus_wdata[PAGE_W-1:0] : '0; // [R7]

  // ****************************************
  // Read data
  // ****************************************
  wire [31:0] stat_word = {empty, full, {(30-AW-1){1'b0}}, level};
  wire [31:0] ctrl_word = {29'h0, ctrl_r.fifo_mode, ctrl_r.fmt};
  wire [31:0] page_word = {{(32-PAGE_W){1'b0}}, page_r};
  wire [31:0] reg_word  = ctrl_hit ? ctrl_word :
                          page_hit ? page_word :
                          stat_hit ? stat_word : 32'h0000_0000;
  wire        berr_nxt  = win_rd && (!fmode || empty); // [R3] [R4]
  wire [31:0] rdata_nxt = !bus_rd ? 32'h0000_0000 :
                          pop     ? head : // [R1] [R14]
                          win_rd  ? 32'h0000_0000 : reg_word;

  // ****************************************
  // User input synchroniser
  // ****************************************
  wire [1:0] usr_nxt = (usr_s2_r == usr_s3_r) ? usr_s3_r : usr_r;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      usr_s1_r <= 2'b00;
      usr_s2_r <= 2'b00;
      usr_s3_r <= 2'b00;
      usr_r    <= 2'b00;
    end else begin
      usr_s1_r <= user_pin;
      usr_s2_r <= usr_s1_r;
      usr_s3_r <= usr_s2_r;
      usr_r    <= usr_nxt;
    end
  end

  // ****************************************
  // Control and bus registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r  <= scr_ctrl_s'(3'(`SCR_CTRL_RST));
      page_r  <= PAGE_W'(`SCR_PAGE_RST);
      rdata_r <= 32'h0000_0000;
      berr_r  <= 1'b0;
      ready_r <= 1'b0;
      acc_r   <= 32'h0000_0000;
      lane_r  <= 2'd0;
    end else begin
      if (ctrl_wr) begin
        ctrl_r <= scr_ctrl_s'(bus_wdata[`SCR_CTRL_MODE:0]);
      end
      if (page_wr) begin
        page_r <= page_nxt; // [R7]
      end
      rdata_r <= rdata_nxt;
      berr_r  <= berr_nxt; // [R3]
      ready_r <= ready_nxt;
      acc_r   <= acc_nxt;
      lane_r  <= lane_nxt;
    end
  end

  assign bus_rdata = rdata_r;
  assign bus_berr  = berr_r;
  assign smp_ready = ready_r;
  assign mem_page  = page_r;

  // ****************************************
  // Assertion helpers
  // ****************************************
  logic [15:0] half_r;

  // Low half of a 16-bit pair, kept apart from the packing register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      half_r <= 16'h0000;
    end else if (take && lane_r == 2'd0) begin
      half_r <= smp.count[15:0];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  empty_berr_a: assert property (win_rd && empty |=> bus_berr) // [R3]
    else $error("empty window read gave no bus error");

  mode_gate_a: assert property (win_rd && !fmode
                                |=> bus_berr && bus_rdata == 0) // [R4]
    else $error("window read outside FIFO mode returned data");

  win_data_a: assert property (pop |=> !bus_berr
                               && bus_rdata == $past(head)) // [R1]
    else $error("window read did not return head word");

  pop_once_a: assert property (pop && !push
                               |=> level == $past(level) - 1) // [R14]
    else $error("window read did not remove exactly one word");

  burst_read_a: assert property (pop ##1 pop // [R5]
                                 |=> !bus_berr && bus_rdata == $past(head))
    else $error("back to back window reads failed");

  no_overflow_a: assert property (smp_ready |-> !full) // [R14]
    else $error("sample port ready while store full");

  fmt32_word_a: assert property (push && ctrl_r.fmt == SCR_FMT32
                                 |-> push_data == smp.count) // [R9]
    else $error("32-bit word not raw count");

  fmt24_word_a: assert property (push && ctrl_r.fmt == SCR_FMT24
                                 |-> push_data[31:30] == usr_r
                                 && push_data[29] == 1'b0
                                 && push_data[28:24] == smp.channel) // [R10]
    else $error("24-bit word tag wrong");

  fmt16_pair_a: assert property (push && ctrl_r.fmt == SCR_FMT16 // [R12]
                                 |-> push_data == {smp.count[15:0], half_r})
    else $error("16-bit pair misplaced");

  fmt8_lane_a: assert property (push && ctrl_r.fmt == SCR_FMT8
                                |-> lane_r == 2'd3
                                && push_data[31:24] == smp.count[7:0]) // [R13]
    else $error("8-bit packing wrong");

  page_sel_a: assert property (page_wr |=> mem_page == // [R7]
                               ((MEM_MB > `SCR_PAGE_MB) ?
                                $past(bus_wdata[PAGE_W-1:0]) : PAGE_W'(0)))
    else $error("page select not applied");

  user_hold_a: assert property (usr_s2_r != usr_s3_r
                                |=> $stable(usr_r)) // [R11]
    else $error("user bit changed before agreement");

  burst_c: cover property (pop [*4]);
  berr_c:  cover property (win_rd && empty ##1 bus_berr);
  fmt16_c: cover property (push && ctrl_r.fmt == SCR_FMT16);
  fmt8_c:  cover property (push && ctrl_r.fmt == SCR_FMT8);
  mode_c:  cover property (win_rd && !fmode);

endmodule : scr_readout

// ==== test/scr_chan_src.sv ====
// Counting channel model that offers samples to the packer
`timescale 1ns/1ps
module scr_chan_src import scr_pkg::*; (
  input  wire logic  clk_sys,
  output scr_sample_s smp,
  output logic       smp_valid,
  input  wire logic  smp_ready
);
  initial begin
    smp       = '1;
    smp_valid = 1'b0;
  end

  // ****************************************
  // Sample handshake
  // ****************************************
  task automatic send(input logic [31:0] cnt, input logic [4:0] ch);
    @(posedge clk_sys);
    smp_valid <= 1'b1;
    smp       <= '{count: cnt, channel: ch};
    @(posedge clk_sys);
    while (smp_ready !== 1'b1) begin
      @(posedge clk_sys);
    end
    smp_valid <= 1'b0;
    smp       <= scr_sample_s'(~{cnt, ch});
  endtask : send
endmodule : scr_chan_src

// ==== test/testbench.sv ====
// Self-checking bench for the scaler readout packer
`timescale 1ns/1ps
`include "scr_map.svh"
module testbench import scr_pkg::*;;
  logic        clk_sys   = 1'b0;
  logic        arst_n    = 1'b0;
  logic [23:0] bus_addr  = 24'h00_0000;
  logic [31:0] bus_wdata = 32'h0000_0000;
  logic        bus_wr    = 1'b0;
  logic        bus_rd    = 1'b0;
  logic [31:0] bus_rdata;
  logic        bus_berr;
  scr_sample_s smp;
  logic        smp_valid;
  logic        smp_ready;
  logic [1:0]  user_pin  = 2'b00;
  logic [2:0]  mem_page;
  logic        rd_d      = 1'b0;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  logic [31:0] c[4];
  logic [23:0] ofs[4];
  int          failures  = 0;
  int          compares  = 0;
  int          s;

  always #5 clk_sys = ~clk_sys;

  scr_readout dut_u (
    .clk_sys(clk_sys), .arst_n(arst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .bus_berr(bus_berr), .smp(smp),
    .smp_valid(smp_valid), .smp_ready(smp_ready),
    .user_pin(user_pin), .mem_page(mem_page));

  scr_chan_src src_u (
    .clk_sys(clk_sys), .smp(smp), .smp_valid(smp_valid),
    .smp_ready(smp_ready));

  // ****************************************
  // Compare, report and bus tasks
  // ****************************************
  task automatic chk(input logic [32:0] g, input logic [32:0] x);
    compares++;
    if (g !== x) begin
      failures++;
      $display("BAD t=%0t got %h expected %h", $time, g, x);
    end
  endtask : chk

  task automatic summarize();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done

  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [23:0] a, input logic [32:0] x);
    exp_q.push_back(x);
    @(posedge clk_sys);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge clk_sys);
    bus_rd   <= 1'b0;
  endtask : rd

  // ****************************************
  // Read result monitor
  // ****************************************
  always @(posedge clk_sys) begin
    if (rd_d) begin
      e = exp_q.pop_front();
      chk({bus_berr, bus_rdata}, e);
    end
    rd_d <= bus_rd;
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    s = $urandom(32'h67c6);
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(`SCR_WIN_BASE, {1'b1, 32'h0000_0000});
    rd(`SCR_OFS_CTRL, {1'b0, `SCR_CTRL_RST});
    rd(24'h00_0200, {1'b0, 32'h0000_0000});
    rd(`SCR_OFS_STAT, {1'b0, 32'h8000_0000});
    wr(`SCR_OFS_PAGE, 32'h0000_0001);
    @(posedge clk_sys);
    chk({30'h0, mem_page}, 33'h0_0000_0000);
    done("reset");
    ofs = '{24'h80_0000, 24'hFF_FFFC, 24'hA1_2344, 24'h80_0000};
    foreach (c[i]) begin
      c[i] = $urandom;
      src_u.send(c[i], 5'(i));
    end
    rd(`SCR_OFS_STAT, {1'b0, 32'h0000_0004});
    foreach (c[i]) begin
      exp_q.push_back({1'b0, c[i]});
      @(posedge clk_sys);
      bus_rd   <= 1'b1;
      bus_addr <= ofs[i];
    end
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    rd(24'hC0_0000, {1'b1, 32'h0000_0000});
    done("fmt32");
    wr(`SCR_OFS_CTRL, 32'h0000_0005);
    user_pin <= 2'b10;
    repeat (6) @(posedge clk_sys);
    c[0] = $urandom;
    src_u.send(c[0], 5'h13);
    user_pin <= 2'b01;
    repeat (6) @(posedge clk_sys);
    rd(`SCR_WIN_BASE, {1'b0, 2'b10, 1'b0, 5'h13, c[0][23:0]});
    done("fmt24");
    wr(`SCR_OFS_CTRL, 32'h0000_0006);
    c[0] = $urandom;
    c[1] = $urandom;
    src_u.send(c[0], 5'h00);
    src_u.send(c[1], 5'h01);
    rd(`SCR_WIN_BASE, {1'b0, c[1][15:0], c[0][15:0]});
    done("fmt16");
    wr(`SCR_OFS_CTRL, 32'h0000_0007);
    foreach (c[i]) begin
      c[i] = $urandom;
      src_u.send(c[i], 5'(i));
    end
    rd(`SCR_WIN_BASE,
       {1'b0, c[3][7:0], c[2][7:0], c[1][7:0], c[0][7:0]});
    done("fmt8");
    wr(`SCR_OFS_CTRL, 32'h0000_0004);
    c[0] = $urandom;
    src_u.send(c[0], 5'h07);
    wr(`SCR_OFS_CTRL, 32'h0000_0000);
    rd(`SCR_WIN_BASE, {1'b1, 32'h0000_0000});
    wr(`SCR_OFS_CTRL, 32'h0000_0004);
    rd(`SCR_WIN_BASE, {1'b0, c[0]});
    done("mode");
    repeat (4) @(posedge clk_sys);
    summarize();
  end

  initial begin
    #100000;
    failures++;
    summarize();
  end
endmodule : testbench
